// File: core/rlse_pkg.sv
// constants and register map of the receive latched event block
// Function
// - e1: 915 of 1000 bad codewords sets crc resync
// - e1: two bad cas words set cas resync
// - e1: three bad fas words set fas resync
// - ts16 under three zeros in 16 frames
// - ts16 all zeros over a multiframe
// - crc4 multiframe event, free 2 ms otherwise
// - align frame event every 250 us
// - status 3 conditions latch rising and falling edge bits
// - clock loss after one idle channel time
// - t1 spare and loop-down match programmed patterns
// - e1 distant mf alarm, two multiframes, edges
// - e1 v5.2 link detect and clear bits
// - elastic store full, empty and slip events
// - enabled channel signalling change sets event
// - one-second event from receive timing
// - timer event on interval or manual latch
// - multiframe event per mode boundary
// - fifo full stops packet, sets overrun
// - packet end and start events, read clears
// - watermark and not-empty rising edges latch
// - t1 rai-ci (esf only) and ais-ci gated by alarms
// - all packet event bits are latched
// - e1 status 2 has no realtime twin
package rlse_pkg;
  localparam int CLK_HZ = 20_000_000;
  // register indices; byte address is four times the index
  localparam logic [11:0] A_ST2E1 = 12'h091;
  localparam logic [11:0] A_ST3   = 12'h092;
  localparam logic [11:0] A_ST4   = 12'h093;
  localparam logic [11:0] A_STPKT = 12'h094;
  localparam logic [11:0] A_ST7   = 12'h096;
  localparam logic [11:0] A_CTRL  = 12'h0c0;
  localparam logic [11:0] A_SPARE = 12'h0c1;
  localparam logic [11:0] A_LDN   = 12'h0c2;
  localparam logic [11:0] A_SIGEN = 12'h0c3;
  localparam logic [11:0] A_HWM   = 12'h0c4;
  // control fields
  localparam int C_E1 = 0;
  localparam int C_ESF = 1;
  localparam int C_CRC4 = 2;
  localparam int C_CAS = 3;
  localparam int C_SHORT = 4;
  localparam int C_LATCH = 5;
  // reset values
  localparam logic [7:0] RST_ST = 8'h00;
  localparam logic [5:0] RST_CTRL = 6'h00;
  localparam logic [15:0] RST_PAT = 16'h0000;
  localparam logic [31:0] RST_SIGEN = 32'h00000000;
  localparam logic [6:0] RST_HWM = 7'h20;
  // detector figures
  localparam logic [9:0] CRC_WIN = 10'd1000;
  localparam logic [9:0] CRC_ERR = 10'd915;
  localparam logic [1:0] CAS_ERRS = 2'd2;
  localparam logic [1:0] FAS_ERRS = 2'd3;
  localparam logic [3:0] TS16_LAST = 4'd15;
  localparam logic [7:0] TS16_ZMIN = 8'd3;
  localparam logic [1:0] DMA_MFS = 2'd2;
  localparam int DMA_IDX = 2;
  localparam logic [6:0] FIFO_DEPTH = 7'd64;
  // timing: one channel time, longest time rounds down
  localparam int CH_T1_NS = 5180;
  localparam int CH_E1_NS = 3906;
  localparam logic [6:0] CH_T1_CYC = 7'(CH_T1_NS * (CLK_HZ / 1_000_000) / 1000);
  localparam logic [6:0] CH_E1_CYC = 7'(CH_E1_NS * (CLK_HZ / 1_000_000) / 1000);
  // timing in received frames of 125 us
  localparam int FRAME_US = 125;
  localparam int AF_US = 250;
  localparam int MF_E1_US = 2000;
  localparam int SEC_US = 1_000_000;
  localparam int T1_SHORT_US = 42000;
  localparam int E1_SHORT_US = 62500;
  localparam logic AF_LAST = 1'(AF_US / FRAME_US - 1);
  localparam logic [4:0] MF_LAST = 5'(MF_E1_US / FRAME_US - 1);
  localparam logic [12:0] SEC_LAST = 13'(SEC_US / FRAME_US - 1);
  localparam logic [12:0] T1S_LAST = 13'(T1_SHORT_US / FRAME_US - 1);
  localparam logic [12:0] E1S_LAST = 13'(E1_SHORT_US / FRAME_US - 1);
endpackage : rlse_pkg

// File: core/rlse_rx_events.sv
// receive latched event registers behind an ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
module rlse_rx_events
  import rlse_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // recovered receive clock pin, asynchronous
  input  wire logic        RCLK_PIN,
  // framer timing strobes
  input  wire logic        FRAME_TICK,
  input  wire logic        CRC4_MF_START,
  input  wire logic        CAS_MF_START,
  input  wire logic        T1_MF_START,
  // e1 alignment checks
  input  wire logic        CRC_CW_TICK,
  input  wire logic        CRC_CW_ERR,
  input  wire logic        CAS_MFAW_TICK,
  input  wire logic        CAS_MFAW_ERR,
  input  wire logic        FAS_TICK,
  input  wire logic        FAS_ERR,
  // timeslot 16 capture
  input  wire logic        TS16_VALID,
  input  wire logic        TS16_FRAME0,
  input  wire logic [7:0]  TS16_BYTE,
  // received data and line codes
  input  wire logic        RX_BYTE_VALID,
  input  wire logic [7:0]  RX_BYTE,
  input  wire logic        LOOP_UP_CODE_MATCH,
  input  wire logic        V52_LINK_ID,
  // elastic store and signalling
  input  wire logic        ES_FULL,
  input  wire logic        ES_EMPTY,
  input  wire logic [31:0] SIG_CHANGE,
  // packet receiver
  input  wire logic        PKT_FIFO_WR,
  input  wire logic [6:0]  PKT_FIFO_LEVEL,
  input  wire logic        PKT_OPEN_BYTE,
  input  wire logic        PKT_END,
  input  wire logic        PKT_START,
  output logic             PKT_STOP,
  // alarm pattern detectors
  input  wire logic        RAI_PRESENT,
  input  wire logic        RAI_CI_DET,
  input  wire logic        AIS_PRESENT,
  input  wire logic        AIS_CI_DET,
  // realtime condition out
  output logic             RX_CLOCK_LOSS
);
  typedef enum logic {BUS_IDLE, BUS_WAIT} rlse_bus_t;

  rlse_bus_t   bus_state;
  logic [11:0] dph_idx;
  logic        dph_write;
  logic        rd_go, wr_go;
  logic [5:0]  ctrl;
  logic [15:0] spare_code_pattern, loop_down_pattern;
  logic [31:0] sig_change_enable;
  logic [6:0]  packet_fifo_control;
  logic [7:0]  st2e1, st3t1, st3e1, st4, stpkt, st7t1;
  logic [31:0] rd_mux;
  logic        e1;

  assign e1 = ctrl[C_E1];
  assign HRESP = 1'b0;
  // wait state lets read data leave a flop
  assign HREADYOUT = (bus_state != BUS_WAIT);
  assign rd_go = (bus_state == BUS_WAIT) && !dph_write;
  assign wr_go = (bus_state == BUS_WAIT) && dph_write;

  // read-clear with a new event winning over the clear
  function automatic logic [7:0] f_latch(input logic [7:0] old, input logic [7:0] set,
                                         input logic clr);
    f_latch = (old & ~{8{clr}}) | set;
  endfunction : f_latch

  function automatic logic [7:0] f_zeros(input logic [7:0] b);
    f_zeros = 8'h00;
    for (int i = 0; i < 8; i++) begin
      f_zeros = f_zeros + {7'h00, ~b[i]};
    end
  endfunction : f_zeros

  // bus phase tracking
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bus_state <= BUS_IDLE;
      dph_idx   <= 12'h000;
      dph_write <= 1'b0;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (HSEL && HTRANS[1] && HREADY) begin
            bus_state <= BUS_WAIT;
            dph_idx   <= HADDR[13:2];
            dph_write <= HWRITE;
          end
        end
        BUS_WAIT: bus_state <= BUS_IDLE;
        default:  bus_state <= BUS_IDLE;
      endcase
    end
  end

  // read decode; unmapped words read zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (dph_idx == A_ST2E1) begin
      rd_mux[7:0] = st2e1;
    end else if (dph_idx == A_ST3) begin
      rd_mux[7:0] = e1 ? st3e1 : st3t1;
    end else if (dph_idx == A_ST4) begin
      rd_mux[7:0] = st4;
    end else if (dph_idx == A_STPKT) begin
      rd_mux[7:0] = stpkt;
    end else if (dph_idx == A_ST7) begin
      rd_mux[7:0] = e1 ? 8'h00 : st7t1;
    end else if (dph_idx == A_CTRL) begin
      rd_mux[5:0] = ctrl;
    end else if (dph_idx == A_SPARE) begin
      rd_mux[15:0] = spare_code_pattern;
    end else if (dph_idx == A_LDN) begin
      rd_mux[15:0] = loop_down_pattern;
    end else if (dph_idx == A_SIGEN) begin
      rd_mux = sig_change_enable;
    end else if (dph_idx == A_HWM) begin
      rd_mux[6:0] = packet_fifo_control;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      HRDATA <= 32'h00000000;
    end else if (rd_go) begin
      HRDATA <= rd_mux;
    end
  end

  // software written configuration; the latch bit never stores
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl                <= RST_CTRL;
      spare_code_pattern  <= RST_PAT;
      loop_down_pattern   <= RST_PAT;
      sig_change_enable   <= RST_SIGEN;
      packet_fifo_control <= RST_HWM;
    end else if (wr_go) begin
      if (dph_idx == A_CTRL) begin
        ctrl <= HWDATA[5:0] & ~(6'h01 << C_LATCH);
      end else if (dph_idx == A_SPARE) begin
        spare_code_pattern <= HWDATA[15:0];
      end else if (dph_idx == A_LDN) begin
        loop_down_pattern <= HWDATA[15:0];
      end else if (dph_idx == A_SIGEN) begin
        sig_change_enable <= HWDATA;
      end else if (dph_idx == A_HWM) begin
        packet_fifo_control <= HWDATA[6:0];
      end
    end
  end

  // receive clock pin: three flops; a new level counts once flops two and three agree
  logic       rclk_s1, rclk_s2, rclk_s3, rclk_f;
  logic [6:0] idle_cnt, idle_lim;
  assign idle_lim = e1 ? CH_E1_CYC : CH_T1_CYC;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rclk_s1 <= 1'b0;
      rclk_s2 <= 1'b0;
      rclk_s3 <= 1'b0;
      rclk_f <= 1'b0;
      idle_cnt <= 7'h00;
      RX_CLOCK_LOSS <= 1'b0;
    end else begin
      rclk_s1 <= RCLK_PIN;
      rclk_s2 <= rclk_s1;
      rclk_s3 <= rclk_s2;
      if (rclk_s2 == rclk_s3 && rclk_s3 != rclk_f) begin // one-sample glitches never count
        rclk_f <= rclk_s3;
        idle_cnt <= 7'h00;
        RX_CLOCK_LOSS <= 1'b0;
      end else if (idle_cnt == idle_lim) begin
        RX_CLOCK_LOSS <= 1'b1;
      end else begin
        idle_cnt <= idle_cnt + 7'h01;
      end
    end
  end

  // frame based interval counters
  logic        af_cnt;
  logic [4:0]  mf_cnt;
  logic [12:0] sec_cnt, tmr_cnt, tmr_lim;
  logic        ev_af, ev_freemf, ev_sec, ev_tmr;
  assign tmr_lim = !ctrl[C_SHORT] ? SEC_LAST : (e1 ? E1S_LAST : T1S_LAST);
  assign ev_af = FRAME_TICK && (af_cnt == AF_LAST);
  assign ev_freemf = FRAME_TICK && (mf_cnt == MF_LAST);
  assign ev_sec = FRAME_TICK && (sec_cnt == SEC_LAST);
  assign ev_tmr = (FRAME_TICK && (tmr_cnt >= tmr_lim)) ||
                  (wr_go && dph_idx == A_CTRL && HWDATA[C_LATCH]);
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      af_cnt <= 1'b0;
      mf_cnt <= 5'h00;
      sec_cnt <= 13'h0000;
      tmr_cnt <= 13'h0000;
    end else if (FRAME_TICK) begin
      af_cnt <= ev_af ? 1'b0 : ~af_cnt;
      mf_cnt <= ev_freemf ? 5'h00 : mf_cnt + 5'h01;
      sec_cnt <= ev_sec ? 13'h0000 : sec_cnt + 13'h0001;
      tmr_cnt <= (tmr_cnt >= tmr_lim) ? 13'h0000 : tmr_cnt + 13'h0001;
    end
  end

  // e1 resync criteria
  logic [9:0] crc_cnt, crc_errs;
  logic [1:0] cas_run, fas_run;
  logic       crc_hit, cas_hit, fas_hit;
  assign crc_hit = CRC_CW_TICK && (crc_cnt == CRC_WIN - 10'd1) &&
                   ((crc_errs + {9'h000, CRC_CW_ERR}) >= CRC_ERR);
  assign cas_hit = CAS_MFAW_TICK && CAS_MFAW_ERR && (cas_run == CAS_ERRS - 2'd1);
  assign fas_hit = FAS_TICK && FAS_ERR && (fas_run == FAS_ERRS - 2'd1);
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      crc_cnt <= 10'h000;
      crc_errs <= 10'h000;
      cas_run <= 2'd0;
      fas_run <= 2'd0;
    end else begin
      if (CRC_CW_TICK) begin
        crc_cnt <= (crc_cnt == CRC_WIN - 10'd1) ? 10'h000 : crc_cnt + 10'h001;
        crc_errs <= (crc_cnt == CRC_WIN - 10'd1) ? 10'h000 : crc_errs + {9'h000, CRC_CW_ERR};
      end
      if (CAS_MFAW_TICK) begin
        cas_run <= (!CAS_MFAW_ERR || cas_hit) ? 2'd0 : cas_run + 2'd1;
      end
      if (FAS_TICK) begin
        fas_run <= (!FAS_ERR || fas_hit) ? 2'd0 : fas_run + 2'd1;
      end
    end
  end

  // timeslot 16 windows of 16 frames, restarted at frame 0
  logic [3:0] ts_cnt;
  logic [7:0] ts_zeros, ts_or, ts_zsum;
  logic [1:0] dma_run;
  logic       ts_end, ev_a1, ev_a0;
  assign ts_zsum = ts_zeros + f_zeros(TS16_BYTE);
  assign ts_end = TS16_VALID && (ts_cnt == TS16_LAST);
  assign ev_a1 = ts_end && (ts_zsum < TS16_ZMIN);
  assign ev_a0 = ts_end && ((ts_or | TS16_BYTE) == 8'h00);
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ts_cnt <= 4'h0;
      ts_zeros <= 8'h00;
      ts_or <= 8'h00;
      dma_run <= 2'd0;
    end else if (TS16_VALID) begin
      // ccs mode does not gate the alarm detectors
      if (ts_end || (TS16_FRAME0 && ts_cnt != 4'h0)) begin
        ts_cnt <= TS16_FRAME0 ? 4'h1 : 4'h0;
        ts_zeros <= TS16_FRAME0 ? f_zeros(TS16_BYTE) : 8'h00;
        ts_or <= TS16_FRAME0 ? TS16_BYTE : 8'h00;
      end else begin
        ts_cnt <= ts_cnt + 4'h1;
        ts_zeros <= ts_zsum;
        ts_or <= ts_or | TS16_BYTE;
      end
      if (TS16_FRAME0) begin
        dma_run <= !TS16_BYTE[DMA_IDX] ? 2'd0 :
                   (dma_run == DMA_MFS) ? DMA_MFS : dma_run + 2'd1;
      end
    end
  end

  // t1 code match over the last two received bytes
  logic [7:0] rx_prev;
  logic       spare_code_match, loop_down_code_match;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rx_prev <= 8'h00;
      spare_code_match <= 1'b0;
      loop_down_code_match <= 1'b0;
    end else if (RX_BYTE_VALID) begin
      rx_prev <= RX_BYTE;
      spare_code_match <= !e1 && ({rx_prev, RX_BYTE} == spare_code_pattern);
      loop_down_code_match <= !e1 && ({rx_prev, RX_BYTE} == loop_down_pattern);
    end
  end

  // realtime conditions and their edges
  logic [7:0] cond, cond_q, rise, fall;
  assign cond = {PKT_FIFO_LEVEL != 7'h00, PKT_FIFO_LEVEL > packet_fifo_control,
                 dma_run == DMA_MFS, V52_LINK_ID, LOOP_UP_CODE_MATCH,
                 loop_down_code_match, spare_code_match, RX_CLOCK_LOSS};
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cond_q <= 8'h00;
    end else begin
      cond_q <= cond;
    end
  end
  for (genvar g = 0; g < 8; g++) begin : g_edge
    assign rise[g] = cond[g] && !cond_q[g];
    assign fall[g] = !cond[g] && cond_q[g];
  end

  // packet receiver stop on overrun until the next packet start
  logic ovr;
  assign ovr = PKT_FIFO_WR && (PKT_FIFO_LEVEL >= FIFO_DEPTH);
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PKT_STOP <= 1'b0;
    end else if (ovr) begin
      PKT_STOP <= 1'b1;
    end else if (PKT_START) begin
      PKT_STOP <= 1'b0;
    end
  end

  // event sources per register
  logic [7:0] set2, set3t, set3e, set4, setp, set7;
  logic       ev_crc4mf, ev_rmf, ev_sig;
  assign ev_crc4mf = ctrl[C_CRC4] ? CRC4_MF_START : ev_freemf;
  assign ev_rmf = e1 ? (ctrl[C_CAS] ? CAS_MF_START : ev_freemf) : T1_MF_START;
  assign ev_sig = |(SIG_CHANGE & sig_change_enable);
  assign set2 = {8{e1}} & {1'b0, crc_hit, cas_hit, fas_hit, ev_a1, ev_a0, ev_crc4mf, ev_af};
  assign set3t = {8{!e1}} & {fall[0], fall[1], fall[2], fall[3],
                             rise[0], rise[1], rise[2], rise[3]};
  assign set3e = {8{e1}} & {fall[0], 1'b0, fall[4], fall[5],
                            rise[0], 1'b0, rise[4], rise[5]};
  assign set4 = {ES_FULL, ES_EMPTY, ES_FULL || ES_EMPTY, 1'b0,
                 ev_sig, ev_sec, ev_tmr, ev_rmf};
  assign setp = {2'b00, ovr, PKT_OPEN_BYTE, PKT_END || ovr, PKT_START,
                 rise[6], rise[7]};
  assign set7 = {2'b00, !e1 && ctrl[C_ESF] && RAI_PRESENT && RAI_CI_DET,
                 !e1 && AIS_PRESENT && AIS_CI_DET, 4'h0};

  // latched status, cleared by the read that returns them
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st2e1 <= RST_ST;
      st3t1 <= RST_ST;
      st3e1 <= RST_ST;
      st4 <= RST_ST;
      stpkt <= RST_ST;
      st7t1 <= RST_ST;
    end else begin
      st2e1 <= f_latch(st2e1, set2, rd_go && dph_idx == A_ST2E1);
      st3t1 <= f_latch(st3t1, set3t, rd_go && dph_idx == A_ST3 && !e1);
      st3e1 <= f_latch(st3e1, set3e, rd_go && dph_idx == A_ST3 && e1);
      st4 <= f_latch(st4, set4, rd_go && dph_idx == A_ST4);
      stpkt <= f_latch(stpkt, setp, rd_go && dph_idx == A_STPKT);
      st7t1 <= f_latch(st7t1, set7, rd_go && dph_idx == A_ST7 && !e1);
    end
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_fas3; (e1 && fas_run == 2'd2 && FAS_TICK && FAS_ERR) |=> st2e1[4]; endproperty
  property p_cas2; (e1 && cas_run == 2'd1 && CAS_MFAW_TICK && CAS_MFAW_ERR) |=> st2e1[5];
  endproperty
  property p_crc; (e1 && crc_hit) |=> st2e1[6] ##1 (st2e1[6] || $past(rd_go)); endproperty
  property p_rx_clock_loss; $rose(RX_CLOCK_LOSS) |=> (e1 ? st3e1[3] : st3t1[3]); endproperty
  property p_rx_clock_loss_idle; (rclk_s2 == rclk_s3 && rclk_s3 != rclk_f) |=> !RX_CLOCK_LOSS; endproperty
  property p_clear; (rd_go && dph_idx == A_ST4 && set4 == 8'h00) |=> st4 == 8'h00; endproperty
  property p_setwins; (rd_go && dph_idx == A_ST4 && ES_FULL) |=> st4[7] && st4[5]; endproperty
  property p_wait; (HSEL && HTRANS[1] && HREADY && HREADYOUT) |=> !HREADYOUT ##1 HREADYOUT;
  endproperty
  property p_sig; (|(SIG_CHANGE & sig_change_enable)) |=> st4[3]; endproperty
  property p_ovr; ovr |=> PKT_STOP && stpkt[5] && stpkt[3]; endproperty

  a_fas3: assert property (p_fas3) else $error("fas resync not set");
  a_cas2: assert property (p_cas2) else $error("cas resync not set");
  a_crc: assert property (p_crc) else $error("crc resync lost");
  a_rx_clock_loss: assert property (p_rx_clock_loss) else $error("clock loss not latched");
  a_rx_clock_loss_idle: assert property (p_rx_clock_loss_idle) else $error("clock loss with edges");
  a_clear: assert property (p_clear) else $error("read did not clear");
  a_setwins: assert property (p_setwins) else $error("event lost on clear");
  a_wait: assert property (p_wait) else $error("bus wait shape wrong");
  a_sig: assert property (p_sig) else $error("signalling change lost");
  a_ovr: assert property (p_ovr) else $error("overrun not handled");

  c_rd: cover property (rd_go && rd_mux != 32'h00000000);
  c_rx_clock_loss: cover property ($rose(RX_CLOCK_LOSS));
  c_a1: cover property (ev_a1);
  c_ovr: cover property (ovr);
endmodule : rlse_rx_events
`default_nettype wire

// File: tb/test_rlse_rx_events.sv
// self-checking bench of the receive latched event registers
`timescale 1ns/1ps
`default_nettype none
module test_rlse_rx_events;
  import rlse_pkg::*;
  typedef struct packed {
    logic [5:0]  c;
    logic [4:0]  b;
    logic [1:0]  p;
    logic [11:0] a;
    logic [7:0]  x;
  } rlse_row_t;
  logic        CLK, RST_N, HREADYOUT, HRESP, PKT_STOP, RX_CLOCK_LOSS;
  logic [31:0] HADDR, HWDATA, HRDATA, sc;
  logic [1:0]  HTRANS;
  logic        HWRITE, RCLK_PIN, rs, er, f0, lu, v52, rai, ais;
  logic [7:0]  tb, rb;
  logic [6:0]  lv;
  logic [17:0] ev;
  int          n_errors, num_checks, cyc;
  // rows: control, event pulse, {rai, ais} levels, register, expected
  localparam rlse_row_t ROWS [13] = '{
    '{6'h00, 5'd6, 2'b00, A_ST4, 8'ha0}, '{6'h00, 5'd7, 2'b00, A_ST4, 8'h60},
    '{6'h00, 5'd9, 2'b00, A_STPKT, 8'h10}, '{6'h00, 5'd10, 2'b00, A_STPKT, 8'h08},
    '{6'h00, 5'd11, 2'b00, A_STPKT, 8'h04}, '{6'h02, 5'd12, 2'b10, A_ST7, 8'h20},
    '{6'h00, 5'd12, 2'b10, A_ST7, 8'h00}, '{6'h00, 5'd13, 2'b01, A_ST7, 8'h10},
    '{6'h00, 5'd13, 2'b00, A_ST7, 8'h00}, '{6'h01, 5'd13, 2'b01, A_ST7, 8'h00},
    '{6'h00, 5'd14, 2'b00, A_ST4, 8'h01}, '{6'h09, 5'd16, 2'b00, A_ST4, 8'h01},
    '{6'h05, 5'd15, 2'b00, A_ST2E1, 8'h02}};
  localparam logic [11:0] RI [10] = '{A_ST2E1, A_ST3, A_ST4, A_STPKT, A_ST7, A_CTRL,
                                      A_SPARE, A_LDN, A_SIGEN, 12'h0ff};

  rlse_rx_events dut (.CLK(CLK), .RST_N(RST_N), .HSEL(1'b1), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .RCLK_PIN(RCLK_PIN), .FRAME_TICK(ev[0]), .CRC4_MF_START(ev[15]),
    .CAS_MF_START(ev[16]), .T1_MF_START(ev[14]), .CRC_CW_TICK(ev[1]), .CRC_CW_ERR(er),
    .CAS_MFAW_TICK(ev[2]), .CAS_MFAW_ERR(er), .FAS_TICK(ev[3]), .FAS_ERR(er),
    .TS16_VALID(ev[4]), .TS16_FRAME0(f0), .TS16_BYTE(tb), .RX_BYTE_VALID(ev[5]),
    .RX_BYTE(rb), .LOOP_UP_CODE_MATCH(lu), .V52_LINK_ID(v52), .ES_FULL(ev[6]),
    .ES_EMPTY(ev[7]), .SIG_CHANGE(ev[17] ? sc : 32'h0), .PKT_FIFO_WR(ev[8]),
    .PKT_FIFO_LEVEL(lv), .PKT_OPEN_BYTE(ev[9]), .PKT_END(ev[10]), .PKT_START(ev[11]),
    .PKT_STOP(PKT_STOP), .RAI_PRESENT(rai), .RAI_CI_DET(ev[12]), .AIS_PRESENT(ais),
    .AIS_CI_DET(ev[13]), .RX_CLOCK_LOSS(RX_CLOCK_LOSS));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // one single ahb-lite word transfer, waits on hready both phases
  task automatic bus(input logic w, input logic [11:0] i, input logic [31:0] d,
                     output logic [31:0] q);
    HTRANS <= 2'b10;
    HADDR <= {18'h0, i, 2'b00};
    HWRITE <= w;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    HTRANS <= 2'b00;
    HWDATA <= d;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    q = HRDATA;
  endtask : bus

  task automatic rd(input logic [11:0] i, input logic [7:0] x);
    logic [31:0] q;
    bus(1'b0, i, 32'h0, q);
    chk(q, {24'h0, x});
    chk({31'h0, HRESP}, 32'h0);
  endtask : rd

  task automatic wr(input logic [11:0] i, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, i, d, q);
  endtask : wr

  // n back-to-back pulses of one strobe, then an idle edge so ev is never set twice
  task automatic pl(input int b, input int n);
    ev <= 18'(1) << b;
    repeat (n) @(posedge CLK);
    ev <= 18'h0;
    @(posedge CLK);
  endtask : pl

  task automatic t16(input logic f, input logic [7:0] b);
    f0 <= f;
    tb <= b;
    pl(4, 1);
  endtask : t16

  task automatic byt(input logic [7:0] b);
    rb <= b;
    pl(5, 1);
  endtask : byt

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // 20 mhz system clock
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  // recovered clock pin toggles every fourth cycle unless stopped; ceiling cuts a hang
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (!rs && cyc[1:0] == 2'b00) RCLK_PIN <= ~RCLK_PIN;
    if (cyc == 40000) begin
      n_errors++;
      close_out();
    end
  end

  // main sequence
  initial begin
    int k;
    {RST_N, HWRITE, rs, er, f0, lu, v52, rai, ais, RCLK_PIN} = '0;
    {HTRANS, HADDR, HWDATA, sc, tb, rb, lv, ev} = '0;
    {n_errors, num_checks, cyc} = '0;
    repeat (4) @(posedge CLK);
    RST_N <= 1'b1;
    foreach (RI[i]) rd(RI[i], 8'h00);
    rd(A_HWM, 8'h20);
    wr(A_ST4, 32'hff);
    rd(A_ST4, 8'h00);
    foreach (ROWS[i]) begin
      wr(A_CTRL, {26'h0, ROWS[i].c});
      {rai, ais} <= ROWS[i].p;
      pl(int'(ROWS[i].b), 1);
      rd(ROWS[i].a, ROWS[i].x);
      rd(ROWS[i].a, 8'h00);
    end
    {rai, ais} <= 2'b00;
    wr(A_CTRL, 32'h20);
    rd(A_ST4, 8'h02);
    wr(A_SIGEN, 32'h80000001);
    sc <= 32'h2;
    pl(17, 1);
    rd(A_ST4, 8'h00);
    sc <= 32'h80000000;
    pl(17, 1);
    rd(A_ST4, 8'h08);
    // fifo level steps: not empty, at watermark, above it, full
    lv <= 7'd1;
    pl(8, 1);
    lv <= 7'd32;
    pl(8, 1);
    rd(A_STPKT, 8'h01);
    lv <= 7'd33;
    pl(8, 1);
    rd(A_STPKT, 8'h02);
    lv <= 7'd64;
    pl(8, 1);
    chk({31'h0, PKT_STOP}, 32'h1);
    rd(A_STPKT, 8'h28);
    pl(11, 1);
    chk({31'h0, PKT_STOP}, 32'h0);
    rd(A_STPKT, 8'h04);
    // t1 code detectors rise and fall
    wr(A_SPARE, 32'h1234);
    wr(A_LDN, 32'h5678);
    foreach (ROWS[i]) if (i < 5) byt(i == 0 ? 8'h12 : i == 1 ? 8'h34 : i == 2 ? 8'h56 :
                                     i == 3 ? 8'h78 : 8'h00);
    lu <= 1'b1;
    repeat (2) @(posedge CLK);
    lu <= 1'b0;
    repeat (2) @(posedge CLK);
    rd(A_ST3, 8'h77);
    rs <= 1'b1;
    repeat (95) @(posedge CLK);
    chk({31'h0, RX_CLOCK_LOSS}, 32'h0);
    k = 0;
    while (RX_CLOCK_LOSS !== 1'b1 && k < 20) begin
      @(posedge CLK);
      k++;
    end
    chk({31'h0, RX_CLOCK_LOSS}, 32'h1);
    rs <= 1'b0;
    repeat (10) @(posedge CLK);
    chk({31'h0, RX_CLOCK_LOSS}, 32'h0);
    rd(A_ST3, 8'h88);
    // e1: link id, distant alarm, ts16 windows
    wr(A_CTRL, 32'h1);
    v52 <= 1'b1;
    repeat (2) @(posedge CLK);
    v52 <= 1'b0;
    t16(1'b1, 8'h04);
    t16(1'b1, 8'h04);
    t16(1'b1, 8'h00);
    rd(A_ST3, 8'h33);
    for (int i = 0; i < 16; i++) t16(i == 0, i == 5 ? 8'hfc : 8'hff);
    rd(A_ST2E1, 8'h08);
    for (int i = 0; i < 16; i++) t16(i == 0, 8'h00);
    rd(A_ST2E1, 8'h04);
    // alignment error runs, one good word breaks the run
    er <= 1'b1;
    pl(3, 2);
    er <= 1'b0;
    pl(3, 1);
    er <= 1'b1;
    pl(3, 2);
    rd(A_ST2E1, 8'h00);
    pl(3, 1);
    pl(2, 2);
    rd(A_ST2E1, 8'h30);
    pl(1, 914);
    er <= 1'b0;
    pl(1, 86);
    rd(A_ST2E1, 8'h00);
    er <= 1'b1;
    pl(1, 915);
    er <= 1'b0;
    pl(1, 85);
    rd(A_ST2E1, 8'h40);
    // frame-timed events, crc4 and cas off
    pl(0, 16);
    rd(A_ST2E1, 8'h03);
    rd(A_ST4, 8'h01);
    pl(0, 7984);
    rd(A_ST4, 8'h07);
    // short t1 timer interval: nothing one frame early, the event on the last frame
    wr(A_CTRL, 32'h10);
    pl(0, 335);
    rd(A_ST4, 8'h00);
    pl(0, 1);
    rd(A_ST4, 8'h02);
    // an event in the cycle of the clearing read survives that read
    fork
      rd(A_ST4, 8'h00);
      begin
        @(posedge CLK);
        pl(6, 1);
      end
    join
    rd(A_ST4, 8'ha0);
    // reset in mid-run returns status, control, watermark and packet stop to rest
    wr(A_HWM, 32'h10);
    rd(A_HWM, 8'h10);
    pl(8, 1);
    chk({31'h0, PKT_STOP}, 32'h1);
    pl(6, 1);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    chk({31'h0, PKT_STOP}, 32'h0);
    rd(A_ST4, 8'h00);
    rd(A_CTRL, 8'h00);
    rd(A_HWM, 8'h20);
    close_out();
  end
endmodule : test_rlse_rx_events
`default_nettype wire
